/* File: hw/sysp_spi_ctrl.v */
// serial port mode control, enable, spi shifter and apb register file
`include "sysp_spi_map.vh"

// Function
// - polarity bit one idles clock high
// - mode 0000-0011 picks master bit clock
// - modes 0100/0101 slave, select honoured/ignored
// - i2c mode codes decoded and reported
// - port works only while enable set
// - enable hands pins over, direction gates drive
// - mode 0100 slave resets while select high
// - master starts on buffer write, no overflow
// - slave overflow sets flag, drops byte
module sysp_spi_ctrl
(
  input wire CLK_SYS,
  input wire RESET_N,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [9:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire TIMER_TICK,
  input wire SCK_IN,
  output reg SCK_OUT,
  output reg SCK_OE,
  input wire SDI,
  output reg SDO,
  output reg SDO_OE,
  input wire SS_N,
  output reg [2:0] I2C_MODE,
  output reg IRQ
);

  // ************************************************************
  // decode helpers
  // ************************************************************

  // master modes are the four lowest codes
  function is_master;
    input [3:0] m;
    begin
      is_master = (m == `SYSP_MODE_M_DIV4) || (m == `SYSP_MODE_M_DIV16) ||
                  (m == `SYSP_MODE_M_DIV64) || (m == `SYSP_MODE_M_TIMER);
    end
  endfunction

  // slave modes, with or without select control
  function is_slave;
    input [3:0] m;
    begin
      is_slave = (m == `SYSP_MODE_S_SEL) || (m == `SYSP_MODE_S_NOSEL);
    end
  endfunction

  // i2c variant code for a mode field value
  function [2:0] i2c_kind;
    input [3:0] m;
    begin
      case (m)
        `SYSP_MODE_I2C_S7: i2c_kind = `SYSP_I2C_S7;
        `SYSP_MODE_I2C_S10: i2c_kind = `SYSP_I2C_S10;
        `SYSP_MODE_I2C_FWM: i2c_kind = `SYSP_I2C_FWM;
        `SYSP_MODE_I2C_S7SP: i2c_kind = `SYSP_I2C_S7SP;
        `SYSP_MODE_I2C_S10SP: i2c_kind = `SYSP_I2C_S10SP;
        default: i2c_kind = `SYSP_I2C_NONE;
      endcase
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************

  reg [7:0] control_q;
  reg [7:0] data_buf_q;
  reg buf_full_q;
  reg [7:0] direction_q;
  reg [7:0] irq_flags_q;
  reg [7:0] irq_enables_q;
  reg cke_q;
  reg [7:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg busy_q;
  reg [5:0] div_cnt_q;
  reg sck_prev_q;
  reg done_q;

  wire [3:0] mode = control_q[3:0];
  wire enabled = control_q[`SYSP_CTL_ENABLE];
  wire polarity = control_q[`SYSP_CTL_POLARITY];
  wire master = enabled & is_master(mode);
  wire slave_on = enabled & is_slave(mode);
  // slave logic held in reset while select is high in mode 0100
  wire slave_hold = slave_on & (mode == `SYSP_MODE_S_SEL) & SS_N;
  wire slave_act = slave_on & ~slave_hold;

  // ************************************************************
  // apb access decode
  // ************************************************************

  wire [7:0] idx = PADDR[9:2];
  wire aligned = (PADDR[1:0] == 2'h0);
  wire setup = PSEL & ~PENABLE & ~PREADY;
  wire access = PSEL & PENABLE & PREADY;
  wire wr = access & PWRITE & ~PSLVERR;
  wire rd = access & ~PWRITE & ~PSLVERR;
  wire [7:0] wd = PWDATA[7:0];

  // known register at this address
  wire mapped = aligned && ((idx == `SYSP_IDX_IRQ_FLAGS) || (idx == `SYSP_IDX_DATA_BUF) ||
                (idx == `SYSP_IDX_CONTROL) || (idx == `SYSP_IDX_DIRECTION) ||
                (idx == `SYSP_IDX_IRQ_ENABLES) || (idx == `SYSP_IDX_STATUS) ||
                (idx == `SYSP_IDX_IRQ_CLEAR) || (idx == `SYSP_IDX_EDGE_SEL));

  wire wr_buf = wr & (idx == `SYSP_IDX_DATA_BUF);
  wire wr_ctl = wr & (idx == `SYSP_IDX_CONTROL);
  wire rd_buf = rd & (idx == `SYSP_IDX_DATA_BUF);
  // buffer writes while shifting are refused and flagged
  wire collide = wr_buf & busy_q;
  wire load = wr_buf & ~busy_q & (master | slave_on);

  // read data mux, unimplemented bits zero
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    case (idx)
      `SYSP_IDX_IRQ_FLAGS: rd_mux = irq_flags_q & 8'h08;
      `SYSP_IDX_DATA_BUF: rd_mux = data_buf_q;
      `SYSP_IDX_CONTROL: rd_mux = control_q;
      `SYSP_IDX_DIRECTION: rd_mux = direction_q;
      `SYSP_IDX_IRQ_ENABLES: rd_mux = irq_enables_q & 8'h08;
      `SYSP_IDX_STATUS: rd_mux = {7'h00, buf_full_q};
      `SYSP_IDX_EDGE_SEL: rd_mux = {7'h00, cke_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // one wait-free access phase: ready raised in the cycle after setup
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end
    else if (CE)
    begin
      PREADY <= setup;
      PSLVERR <= setup & ~mapped;
      if (setup)
        PRDATA <= (mapped && !PWRITE) ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  // ************************************************************
  // master bit clock
  // ************************************************************

  // half period for the selected divided rate
  reg [5:0] half_len;
  always @*
  begin
    case (mode)
      `SYSP_MODE_M_DIV16: half_len = `SYSP_HALF_DIV16;
      `SYSP_MODE_M_DIV64: half_len = `SYSP_HALF_DIV64;
      default: half_len = `SYSP_HALF_DIV4;
    endcase
  end

  // timer mode toggles on each tick, giving timer output over two
  wire div_end = (div_cnt_q == half_len - 6'h01);
  wire half_tick = (mode == `SYSP_MODE_M_TIMER) ? TIMER_TICK : div_end;

  // ************************************************************
  // shift edges
  // ************************************************************

  // master edges come from its own toggle, slave edges from the pin
  wire m_edge = master & busy_q & half_tick;
  wire m_lead = m_edge & (SCK_OUT == polarity);
  wire m_trail = m_edge & (SCK_OUT != polarity);
  wire s_edge = slave_act & (SCK_IN != sck_prev_q);
  wire s_lead = s_edge & (SCK_IN != polarity);
  wire s_trail = s_edge & (SCK_IN == polarity);
  wire lead = m_lead | s_lead;
  wire trail = m_trail | s_trail;
  // edge select one samples on the leading edge, zero on the trailing
  wire sample = cke_q ? lead : trail;
  wire drive = cke_q ? trail : lead;
  wire last_sample = sample & (bit_cnt_q == 4'h7);
  // master ends on its eighth trailing edge, so exactly eight clock pulses leave the pin
  wire m_finish = m_trail & ((bit_cnt_q == 4'h8) | (~cke_q & (bit_cnt_q == 4'h7)));
  wire s_finish = slave_act & last_sample;
  wire [7:0] rx_byte = {shift_q[6:0], SDI};

  // shift register and bit counter
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      busy_q <= 1'b0;
      div_cnt_q <= 6'h00;
      sck_prev_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (CE)
    begin
      sck_prev_q <= SCK_IN;
      done_q <= 1'b0;
      if (!enabled || slave_hold || wr_ctl)
      begin
        bit_cnt_q <= 4'h0;
        busy_q <= 1'b0;
        div_cnt_q <= 6'h00;
      end
      else if (load)
      begin
        shift_q <= wd;
        bit_cnt_q <= 4'h0;
        busy_q <= master;
        div_cnt_q <= 6'h00;
      end
      else
      begin
        if (master && busy_q)
          div_cnt_q <= half_tick ? 6'h00 : div_cnt_q + 6'h01;
        if (sample && bit_cnt_q != 4'h8)
        begin
          shift_q <= rx_byte;
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (m_finish)
        begin
          busy_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          done_q <= 1'b1;
        end
        else if (s_finish)
        begin
          bit_cnt_q <= 4'h0;
          busy_q <= 1'b0; // next byte may be preloaded between frames
          done_q <= 1'b1;
        end
        else if (slave_act && s_edge)
          busy_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // registers written by software and set by hardware
  // ************************************************************

  wire complete = done_q;
  wire overflow = complete & ~master & buf_full_q;
  wire store = complete & ~overflow;

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      control_q <= `SYSP_RST_CONTROL;
      data_buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      direction_q <= `SYSP_RST_DIRECTION;
      irq_flags_q <= `SYSP_RST_IRQ;
      irq_enables_q <= `SYSP_RST_IRQ;
      cke_q <= 1'b0;
    end
    else if (CE)
    begin
      // flag bits: hardware set wins over a software clear
      if (wr_ctl)
        control_q <= {wd[7] & control_q[7] | collide, wd[6] & control_q[6] | overflow, wd[5:0]};
      else
      begin
        control_q[`SYSP_CTL_COLLISION] <= control_q[`SYSP_CTL_COLLISION] | collide;
        control_q[`SYSP_CTL_OVERFLOW] <= control_q[`SYSP_CTL_OVERFLOW] | overflow;
      end
      if (store)
        data_buf_q <= shift_q;
      else if (load)
        data_buf_q <= wd;
      buf_full_q <= store | (buf_full_q & ~rd_buf);
      if (wr && idx == `SYSP_IDX_DIRECTION)
        direction_q <= wd;
      if (wr && idx == `SYSP_IDX_IRQ_ENABLES)
        irq_enables_q <= wd & 8'h08;
      if (wr && idx == `SYSP_IDX_EDGE_SEL)
        cke_q <= wd[`SYSP_EDGE_CKE];
      irq_flags_q[`SYSP_IRQ_PORT] <= complete |
        (irq_flags_q[`SYSP_IRQ_PORT] & ~(wr && idx == `SYSP_IDX_IRQ_CLEAR && wd[`SYSP_IRQ_PORT]));
    end
  end

  // ************************************************************
  // pins and outputs
  // ************************************************************

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SCK_OUT <= 1'b0;
      SCK_OE <= 1'b0;
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
      I2C_MODE <= `SYSP_I2C_NONE;
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      // clock idles at the polarity level, toggles on each half tick
      if (!master || !busy_q || load)
        SCK_OUT <= polarity;
      else if (m_edge && !m_finish)
        SCK_OUT <= ~SCK_OUT;
      else if (m_finish)
        SCK_OUT <= polarity;
      if (load)
        SDO <= wd[7];
      else if (drive)
        SDO <= shift_q[7];
      // pins belong to the port only while enabled, direction decides drive
      SCK_OE <= master & ~direction_q[`SYSP_DIR_SCK];
      SDO_OE <= (master | slave_act) & ~direction_q[`SYSP_DIR_SDO];
      I2C_MODE <= enabled ? i2c_kind(mode) : `SYSP_I2C_NONE;
      IRQ <= |(irq_flags_q & irq_enables_q);
    end
  end

endmodule

/* File: hw/sysp_spi_map.vh */
// register indices, field positions, reset values and mode codes of the serial port control block
`ifndef SYSP_SPI_MAP_VH
`define SYSP_SPI_MAP_VH
// register indices (byte address is four times the index)
`define SYSP_IDX_IRQ_FLAGS 8'h0C
`define SYSP_IDX_DATA_BUF 8'h13
`define SYSP_IDX_CONTROL 8'h14
`define SYSP_IDX_DIRECTION 8'h87
`define SYSP_IDX_IRQ_ENABLES 8'h8C
`define SYSP_IDX_STATUS 8'h94
`define SYSP_IDX_IRQ_CLEAR 8'hA0
`define SYSP_IDX_EDGE_SEL 8'hA1
// control register fields
`define SYSP_CTL_COLLISION 7
`define SYSP_CTL_OVERFLOW 6
`define SYSP_CTL_ENABLE 5
`define SYSP_CTL_POLARITY 4
// status, interrupt, direction and edge select fields
`define SYSP_STAT_FULL 0
`define SYSP_IRQ_PORT 3
`define SYSP_DIR_SCK 3
`define SYSP_DIR_SDI 4
`define SYSP_DIR_SDO 5
`define SYSP_EDGE_CKE 0
// reset values
`define SYSP_RST_CONTROL 8'h00
`define SYSP_RST_IRQ 8'h00
`define SYSP_RST_STATUS 8'h00
`define SYSP_RST_DIRECTION 8'hFF
`define SYSP_RST_EDGE 8'h00
// mode field codes
`define SYSP_MODE_M_DIV4 4'h0
`define SYSP_MODE_M_DIV16 4'h1
`define SYSP_MODE_M_DIV64 4'h2
`define SYSP_MODE_M_TIMER 4'h3
`define SYSP_MODE_S_SEL 4'h4
`define SYSP_MODE_S_NOSEL 4'h5
`define SYSP_MODE_I2C_S7 4'h6
`define SYSP_MODE_I2C_S10 4'h7
`define SYSP_MODE_I2C_FWM 4'hB
`define SYSP_MODE_I2C_S7SP 4'hE
`define SYSP_MODE_I2C_S10SP 4'hF
// half bit periods in system clocks for the divided master rates
`define SYSP_HALF_DIV4 6'h02
`define SYSP_HALF_DIV16 6'h08
`define SYSP_HALF_DIV64 6'h20
// i2c selection codes shown on the i2c mode output
`define SYSP_I2C_NONE 3'h0
`define SYSP_I2C_S7 3'h1
`define SYSP_I2C_S10 3'h2
`define SYSP_I2C_FWM 3'h3
`define SYSP_I2C_S7SP 3'h5
`define SYSP_I2C_S10SP 3'h6
`endif

/* File: test/sysp_chk_asserts.sv */
// checker on the ports of the serial port control block
module sysp_chk
(
  input wire CLK_SYS,
  input wire RESET_N,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire [9:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire TIMER_TICK,
  input wire SCK_OUT,
  input wire SCK_OE,
  input wire [2:0] I2C_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // port assertions
  // ****
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  setup_gets_ready_a: assert property (PSEL && !PENABLE && !PREADY && CE |=> PREADY)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (PREADY && CE |=> !PREADY)
    else $error("ready held too long");
  misaligned_err_a: assert property (PSEL && !PENABLE && !PREADY && CE && PADDR[1:0] != 2'h0 |=> PSLVERR)
    else $error("misaligned access not refused");
  upper_read_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  i2c_code_legal_a: assert property (I2C_MODE != 3'h4 && I2C_MODE != 3'h7)
    else $error("undefined i2c mode code");
  i2c_no_clock_a: assert property (I2C_MODE != 3'h0 |-> !SCK_OE)
    else $error("clock driven in i2c mode");
  sck_half_min_a: assert property ($changed(SCK_OUT) && !$past(TIMER_TICK) && !$past(TIMER_TICK, 2) |=> $stable(SCK_OUT))
    else $error("serial clock half period too short");
  ce_freeze_a: assert property (!CE |=> $stable(PREADY) && $stable(SCK_OUT) && $stable(I2C_MODE))
    else $error("outputs moved while clock enable low");
  // main scenarios reached
  cover property (PREADY && PSLVERR);
  cover property (I2C_MODE == 3'h6);
  cover property ($rose(SCK_OUT) && SCK_OE);
endmodule
bind sysp_spi_ctrl sysp_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_TICK(TIMER_TICK),
  .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .I2C_MODE(I2C_MODE));

/* File: test/sysp_peer.sv */
// behavioural serial slave facing the port in master mode
module sysp_peer
(
  input wire clk,
  input wire rst_n,
  input wire sck,
  input wire pol,
  input wire mosi,
  input wire [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [2:0] cnt;
  logic [5:0] idle;
  // ****
  // bit engine
  // ****
  // leading edge puts out the next bit, trailing edge takes one in, msb first
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_q <= 1'h0;
      cnt <= 3'h0;
      idle <= 6'h00;
      miso <= 1'h0;
      rx <= 8'h00;
    end
    else
    begin
      sck_q <= sck;
      idle <= (sck != sck_q) ? 6'h00 : (idle == 6'h3F ? idle : idle + 6'h01);
      if (sck != sck_q && sck != pol)
      begin
        miso <= tx[3'h7 - cnt];
        cnt <= cnt + 3'h1;
      end
      if (sck != sck_q && sck == pol)
        rx <= {rx[6:0], mosi};
      if (idle == 6'h3E)
      begin
        cnt <= 3'h0;
        miso <= ~miso; // released line no longer shows the last bit
      end
    end
  end
endmodule

/* File: test/testbench.sv */
// self-checking testbench of the serial port control block
`include "sysp_spi_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, RESET_N, CE, PSEL, PENABLE, PWRITE, TIMER_TICK, SCK_IN, SS_N, pol, er;
  logic PREADY, PSLVERR, SCK_OUT, SCK_OE, SDI, SDO, SDO_OE, IRQ;
  logic [9:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [2:0] I2C_MODE;
  logic [1:0] tcnt;
  logic [7:0] rd, prx;
  int n_fail, compares;
  sysp_spi_ctrl DUT (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TIMER_TICK(TIMER_TICK), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDI(SDI), .SDO(SDO),
    .SDO_OE(SDO_OE), .SS_N(SS_N), .I2C_MODE(I2C_MODE), .IRQ(IRQ));
  sysp_peer peer (.clk(CLK_SYS), .rst_n(RESET_N), .sck(SCK_OUT), .pol(pol), .mosi(SDO), .tx(8'h3C),
    .miso(SDI), .rx(prx));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is seen
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'h1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'h1)
      @(posedge CLK_SYS);
    rd = PRDATA[7:0];
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'h1, {i, 2'h0}, d);
  endtask
  task automatic rdr(input logic [7:0] i);
    apb(1'h0, {i, 2'h0}, 8'h00);
  endtask
  // disable, rewrite with the new value, then wait two cycles
  task automatic cfg(input logic [7:0] v);
    wr(`SYSP_IDX_CONTROL, 8'h00);
    wr(`SYSP_IDX_CONTROL, v);
    repeat (2) @(posedge CLK_SYS);
  endtask
  task automatic pulses;
    repeat (8)
    begin
      SCK_IN <= 1'h1;
      repeat (2) @(posedge CLK_SYS);
      SCK_IN <= 1'h0;
      repeat (2) @(posedge CLK_SYS);
    end
    repeat (4) @(posedge CLK_SYS);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rdr(`SYSP_IDX_CONTROL);
    chk(rd, `SYSP_RST_CONTROL);
    rdr(`SYSP_IDX_IRQ_FLAGS);
    chk(rd, `SYSP_RST_IRQ);
    wr(`SYSP_IDX_STATUS, 8'hFF);
    rdr(`SYSP_IDX_STATUS);
    chk(rd, `SYSP_RST_STATUS);
    apb(1'h0, 10'h051, 8'h00);
    chk(er, 1'h1);
    CE <= 1'h0;
    repeat (3) @(posedge CLK_SYS);
    CE <= 1'h1;
  endtask
  task automatic t_i2c;
    logic [3:0] code [5] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
    logic [2:0] expm [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    for (int i = 0; i < 5; i++)
    begin
      cfg({4'h2, code[i]});
      chk(I2C_MODE, expm[i]);
    end
    cfg(8'h06);
    chk(I2C_MODE, 3'h0);
  endtask
  task automatic t_master(input logic [3:0] m);
    pol = m[0];
    wr(`SYSP_IDX_DIRECTION, 8'hD7);
    wr(`SYSP_IDX_IRQ_ENABLES, 8'h08);
    cfg({3'h1, pol, m});
    repeat (70) @(posedge CLK_SYS);
    chk(SCK_OUT, pol);
    chk(SCK_OE, 1'h1);
    chk(SDO_OE, 1'h1);
    wr(`SYSP_IDX_DATA_BUF, 8'hA5);
    wr(`SYSP_IDX_DATA_BUF, 8'h5A);
    for (int i = 0; i < 3000 && IRQ !== 1'h1; i++)
      @(posedge CLK_SYS);
    chk(IRQ, 1'h1);
    chk(prx, 8'hA5);
    rdr(`SYSP_IDX_DATA_BUF);
    chk(rd, 8'h3C);
    rdr(`SYSP_IDX_CONTROL);
    chk(rd & 8'hC0, 8'h80);
    wr(`SYSP_IDX_IRQ_CLEAR, 8'h08);
    @(posedge CLK_SYS);
    chk(IRQ, 1'h0);
  endtask
  // edge select stays zero, so both slave modes are legal here
  task automatic t_slave;
    cfg(8'h25);
    chk(SDO_OE, 1'h1);
    pulses();
    pulses();
    rdr(`SYSP_IDX_CONTROL);
    chk(rd & 8'h40, 8'h40);
    rdr(`SYSP_IDX_STATUS);
    chk(rd & 8'h01, 8'h01);
    cfg(8'h24);
    rdr(`SYSP_IDX_DATA_BUF);
    wr(`SYSP_IDX_IRQ_CLEAR, 8'h08);
    pulses();
    chk(IRQ, 1'h0);
    chk(SDO_OE, 1'h0);
    SS_N <= 1'h0;
    pulses();
    chk(IRQ, 1'h1);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****
  // clock, timer tick, sequence and watchdog
  // ****
  initial
  begin
    CLK_SYS = 1'h0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      tcnt <= 2'h0;
      TIMER_TICK <= 1'h0;
    end
    else
    begin
      tcnt <= tcnt + 2'h1;
      TIMER_TICK <= (tcnt == 2'h2);
    end
  end
  initial
  begin
    {RESET_N, PSEL, PENABLE, PWRITE, SCK_IN, pol} = 6'h00;
    {CE, SS_N, PADDR, PWDATA} = {2'h3, 42'h00000000000};
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge CLK_SYS);
    RESET_N <= 1'h1;
    @(posedge CLK_SYS);
    t_regs();
    t_i2c();
    for (int m = 0; m < 4; m++)
      t_master(m[3:0]);
    t_slave();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    n_fail++;
    report_and_stop();
  end
endmodule
